// *** logic/proc_state_pkg.sv ***
// Summary of operation
// [RL1] state register is 32-bit read/write and clears to zero on reset
// [RL2] user-mode cache lock without permit traps as data storage, sets lock flag
// [RL3] vector instructions without vector permit raise unavailable, set syndrome bit; code only raises vector_unavail, no syndrome bit is kept
// [RL4] idle permit gates power saving; mode picked by config register idle bits
// [RL5] critical gate blocks critical input and watchdog interrupts when zero
// [RL6] external gate blocks external, decrementer and fixed-interval interrupts when zero
// [RL7] user mode flag one refuses privileged instructions and resources
// [RL8] float available zero makes any float instruction raise float unavailable
// [RL9] float available one with base float instruction raises unimplemented operation
// [RL10] machine check gate blocks asynchronous machine check interrupts when zero
// [RL11] debug gate blocks debug interrupts when zero
// [RL12] two float exception mode bits are stored but have no effect
// [RL13] reserved and preserved bits read zero, writes ignored
// [RL14] machine check saves address and state; return restores state
// [RL15] enabled debug saves address and state; return from debug restores
// [RL16] a software write governs every following instruction
package proc_state_pkg;
  localparam int unsigned addr_w = 6;
  localparam logic [addr_w-1:0] off_state = 6'h00;
  localparam logic [addr_w-1:0] off_mchk_addr = 6'h04;
  localparam logic [addr_w-1:0] off_mchk_state = 6'h08;
  localparam logic [addr_w-1:0] off_dbg_addr = 6'h0C;
  localparam logic [addr_w-1:0] off_dbg_state = 6'h10;
  localparam logic [addr_w-1:0] off_config = 6'h14;
  localparam logic [addr_w-1:0] off_status = 6'h18;
  localparam logic [31:0] state_reset = 32'h0;
  localparam int unsigned b_user_lock_permit = 26;
  localparam int unsigned b_vector_unit_avail = 25;
  localparam int unsigned b_idle_permit = 18;
  localparam int unsigned b_crit_irq_gate = 17;
  localparam int unsigned b_ext_irq_gate = 15;
  localparam int unsigned b_user_mode_flag = 14;
  localparam int unsigned b_float_avail = 13;
  localparam int unsigned b_mchk_async_gate = 12;
  localparam int unsigned b_float_exc_mode_zero = 11;
  localparam int unsigned b_dbg_irq_gate = 9;
  localparam int unsigned b_float_exc_mode_one = 8;
  localparam logic [31:0] state_mask = 32'h0606FB00;
  localparam int unsigned b_light_idle = 0;
  localparam int unsigned b_medium_idle = 1;
  localparam int unsigned b_deep_idle = 2;
  localparam int unsigned b_dbg_save_en = 3;
  localparam logic [31:0] config_mask = 32'h0000000F;
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;
  typedef enum logic [1:0] {ev_none, ev_mchk, ev_dbg} entry_t;
endpackage : proc_state_pkg

// *** logic/irq_gate.sv ***
`timescale 1ns/1ps
`default_nettype none
module irq_gate
  import proc_state_pkg::*;
(
  input wire logic [31:0] state,
  input wire logic crit_in_req,
  input wire logic watchdog_req,
  input wire logic ext_in_req,
  input wire logic decr_req,
  input wire logic fit_req,
  input wire logic mchk_async_req,
  input wire logic dbg_req,
  output logic crit_take,
  output logic ext_take,
  output logic mchk_take,
  output logic dbg_take
);
  assign crit_take = state[b_crit_irq_gate] & (crit_in_req | watchdog_req); // [RL5]
  assign ext_take = state[b_ext_irq_gate] & (ext_in_req | decr_req | fit_req); // [RL6]
  assign mchk_take = state[b_mchk_async_gate] & mchk_async_req; // [RL10]
  assign dbg_take = state[b_dbg_irq_gate] & dbg_req; // [RL11]
endmodule : irq_gate
`default_nettype wire

// *** logic/insn_check.sv ***
`timescale 1ns/1ps
`default_nettype none
module insn_check
  import proc_state_pkg::*;
(
  input wire logic [31:0] state,
  input wire logic insn_valid,
  input wire logic insn_privileged,
  input wire logic insn_cache_lock,
  input wire logic insn_lock_is_data,
  input wire logic insn_vector,
  input wire logic insn_float,
  output logic priv_fault,
  output logic lock_fault,
  output logic set_data_lock_flag,
  output logic set_ifetch_lock_flag,
  output logic vector_unavail,
  output logic float_unavail,
  output logic unimpl_op
);
  logic user;
  assign user = state[b_user_mode_flag]; // [RL7]
  assign priv_fault = insn_valid & user & insn_privileged; // [RL7]
  assign lock_fault = insn_valid & insn_cache_lock & user & ~state[b_user_lock_permit]; // [RL2]
  assign set_data_lock_flag = lock_fault & insn_lock_is_data; // [RL2]
  assign set_ifetch_lock_flag = lock_fault & ~insn_lock_is_data; // [RL2]
  assign vector_unavail = insn_valid & insn_vector & ~state[b_vector_unit_avail]; // [RL3]
  assign float_unavail = insn_valid & insn_float & ~state[b_float_avail]; // [RL8]
  assign unimpl_op = insn_valid & insn_float & state[b_float_avail]; // [RL9]
endmodule : insn_check
`default_nettype wire

// *** logic/processor_state_register.sv ***
`timescale 1ns/1ps
`default_nettype none
module processor_state_register
  import proc_state_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [proc_state_pkg::addr_w-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [proc_state_pkg::addr_w-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] resume_addr,
  input wire logic mchk_async_req,
  input wire logic mchk_sync_req,
  input wire logic dbg_req,
  input wire logic crit_in_req,
  input wire logic watchdog_req,
  input wire logic ext_in_req,
  input wire logic decr_req,
  input wire logic fit_req,
  input wire logic ret_mchk,
  input wire logic ret_dbg,
  input wire logic idle_request,
  input wire logic insn_valid,
  input wire logic insn_privileged,
  input wire logic insn_cache_lock,
  input wire logic insn_lock_is_data,
  input wire logic insn_vector,
  input wire logic insn_float,
  output logic [31:0] state_out,
  output logic crit_take,
  output logic ext_take,
  output logic mchk_take,
  output logic dbg_take,
  output logic priv_fault,
  output logic lock_fault,
  output logic set_data_lock_flag,
  output logic set_ifetch_lock_flag,
  output logic vector_unavail,
  output logic float_unavail,
  output logic unimpl_op,
  output logic idle_light,
  output logic idle_medium,
  output logic idle_deep
);
  logic [31:0] processor_state_reg;
  logic [31:0] mchk_return_addr;
  logic [31:0] mchk_saved_state;
  logic [31:0] dbg_return_addr;
  logic [31:0] dbg_saved_state;
  logic [31:0] core_config_reg_zero;
  logic aw_held;
  logic w_held;
  logic [addr_w-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic mchk_entry;
  logic dbg_entry;
  logic dbg_save_on;
  logic [31:0] next_state;
  entry_t last_entry;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction : merge

  function automatic logic mapped(input logic [addr_w-1:0] a);
    return a == off_state || a == off_mchk_addr || a == off_mchk_state ||
           a == off_dbg_addr || a == off_dbg_state || a == off_config || a == off_status;
  endfunction : mapped

  // write channel capture, either order
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign do_write = aw_held & w_held & ~s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (do_write)
    begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (do_write)
    begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= resp_okay;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(aw_addr) ? resp_okay : resp_slverr;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // interrupt entry and return
  assign dbg_save_on = core_config_reg_zero[b_dbg_save_en];
  assign mchk_entry = mchk_take | mchk_sync_req; // [RL14]
  assign dbg_entry = dbg_take & dbg_save_on & ~mchk_entry; // [RL15]

  always_comb
  begin
    next_state = processor_state_reg;
    if (do_write && aw_addr == off_state)
    begin
      next_state = merge(processor_state_reg, w_data, w_strb, state_mask); // [RL13]
    end
    if (ret_mchk)
    begin
      next_state = mchk_saved_state & state_mask; // [RL14]
    end
    else if (ret_dbg && dbg_save_on)
    begin
      next_state = dbg_saved_state & state_mask; // [RL15]
    end
    if (mchk_entry)
    begin
      next_state = state_reset; // [RL14]
    end
    else if (dbg_entry)
    begin
      next_state = processor_state_reg & ~(32'h1 << b_dbg_irq_gate); // [RL15]
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      processor_state_reg <= state_reset; // [RL1]
    end
    else
    begin
      processor_state_reg <= next_state; // [RL16]
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mchk_return_addr <= '0;
      mchk_saved_state <= '0;
    end
    else if (mchk_entry)
    begin
      mchk_return_addr <= resume_addr; // [RL14]
      mchk_saved_state <= processor_state_reg; // [RL14]
    end
    else if (do_write && aw_addr == off_mchk_addr)
    begin
      mchk_return_addr <= merge(mchk_return_addr, w_data, w_strb, 32'hFFFFFFFF);
    end
    else if (do_write && aw_addr == off_mchk_state)
    begin
      mchk_saved_state <= merge(mchk_saved_state, w_data, w_strb, state_mask);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dbg_return_addr <= '0;
      dbg_saved_state <= '0;
    end
    else if (dbg_entry)
    begin
      dbg_return_addr <= resume_addr; // [RL15]
      dbg_saved_state <= processor_state_reg; // [RL15]
    end
    else if (do_write && aw_addr == off_dbg_addr)
    begin
      dbg_return_addr <= merge(dbg_return_addr, w_data, w_strb, 32'hFFFFFFFF);
    end
    else if (do_write && aw_addr == off_dbg_state)
    begin
      dbg_saved_state <= merge(dbg_saved_state, w_data, w_strb, state_mask);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_config_reg_zero <= '0;
    end
    else if (do_write && aw_addr == off_config)
    begin
      core_config_reg_zero <= merge(core_config_reg_zero, w_data, w_strb, config_mask);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      last_entry <= ev_none;
    end
    else if (mchk_entry)
    begin
      last_entry <= ev_mchk;
    end
    else if (dbg_entry)
    begin
      last_entry <= ev_dbg;
    end
  end

  // read channel
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= resp_okay;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? resp_okay : resp_slverr;
      case (s_axi_araddr)
        off_state: s_axi_rdata <= processor_state_reg & state_mask; // [RL13]
        off_mchk_addr: s_axi_rdata <= mchk_return_addr;
        off_mchk_state: s_axi_rdata <= mchk_saved_state;
        off_dbg_addr: s_axi_rdata <= dbg_return_addr;
        off_dbg_state: s_axi_rdata <= dbg_saved_state;
        off_config: s_axi_rdata <= core_config_reg_zero;
        off_status: s_axi_rdata <= {30'h0, last_entry};
        default: s_axi_rdata <= 32'h0;
      endcase
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // float exception mode bits only stored, no consumer
  assign state_out = processor_state_reg; // [RL12]

  // power management
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      idle_light <= 1'b0;
      idle_medium <= 1'b0;
      idle_deep <= 1'b0;
    end
    else
    begin
      idle_light <= processor_state_reg[b_idle_permit] & idle_request &
                    core_config_reg_zero[b_light_idle]; // [RL4]
      idle_medium <= processor_state_reg[b_idle_permit] & idle_request &
                     core_config_reg_zero[b_medium_idle]; // [RL4]
      idle_deep <= processor_state_reg[b_idle_permit] & idle_request &
                   core_config_reg_zero[b_deep_idle]; // [RL4]
    end
  end

  irq_gate u_irq_gate (
    .state(processor_state_reg),
    .crit_in_req(crit_in_req),
    .watchdog_req(watchdog_req),
    .ext_in_req(ext_in_req),
    .decr_req(decr_req),
    .fit_req(fit_req),
    .mchk_async_req(mchk_async_req),
    .dbg_req(dbg_req),
    .crit_take(crit_take),
    .ext_take(ext_take),
    .mchk_take(mchk_take),
    .dbg_take(dbg_take)
  );

  insn_check u_insn_check (
    .state(processor_state_reg),
    .insn_valid(insn_valid),
    .insn_privileged(insn_privileged),
    .insn_cache_lock(insn_cache_lock),
    .insn_lock_is_data(insn_lock_is_data),
    .insn_vector(insn_vector),
    .insn_float(insn_float),
    .priv_fault(priv_fault),
    .lock_fault(lock_fault),
    .set_data_lock_flag(set_data_lock_flag),
    .set_ifetch_lock_flag(set_ifetch_lock_flag),
    .vector_unavail(vector_unavail),
    .float_unavail(float_unavail),
    .unimpl_op(unimpl_op)
  );
endmodule : processor_state_register
`default_nettype wire

// *** verification/core_side_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// instruction stream and interrupt sources of the core
module core_side_model
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] rnd,
  output logic insn_valid,
  output logic insn_privileged,
  output logic insn_cache_lock,
  output logic insn_lock_is_data,
  output logic insn_vector,
  output logic insn_float,
  output logic crit_in_req,
  output logic watchdog_req,
  output logic ext_in_req,
  output logic decr_req,
  output logic fit_req,
  output logic idle_request
);
  // new instruction class and request levels each cycle
  always_ff @(posedge aclk)
  begin
    {insn_valid, insn_privileged, insn_cache_lock, insn_lock_is_data, insn_vector,
      insn_float, crit_in_req, watchdog_req, ext_in_req, decr_req, fit_req,
      idle_request} <= aresetn ? rnd[11:0] : 12'h000;
  end
endmodule : core_side_model
`default_nettype wire

// *** verification/proc_state_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module proc_state_checker
  import proc_state_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] state_out,
  input wire logic crit_in_req,
  input wire logic watchdog_req,
  input wire logic ext_in_req,
  input wire logic decr_req,
  input wire logic fit_req,
  input wire logic mchk_async_req,
  input wire logic mchk_sync_req,
  input wire logic dbg_req,
  input wire logic idle_request,
  input wire logic insn_valid,
  input wire logic insn_privileged,
  input wire logic insn_cache_lock,
  input wire logic insn_lock_is_data,
  input wire logic insn_vector,
  input wire logic insn_float,
  input wire logic crit_take,
  input wire logic ext_take,
  input wire logic mchk_take,
  input wire logic dbg_take,
  input wire logic priv_fault,
  input wire logic lock_fault,
  input wire logic set_data_lock_flag,
  input wire logic set_ifetch_lock_flag,
  input wire logic vector_unavail,
  input wire logic float_unavail,
  input wire logic unimpl_op,
  input wire logic idle_light
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_reserved_zero: assert property ((state_out & ~state_mask) == 32'h0)
    else $error("reserved state bit set");
  chk_crit_gate: assert property (crit_take ==
    (state_out[b_crit_irq_gate] && (crit_in_req || watchdog_req))) else $error("crit gate");
  chk_ext_gate: assert property (ext_take ==
    (state_out[b_ext_irq_gate] && (ext_in_req || decr_req || fit_req))) else $error("ext gate");
  chk_mchk_gate: assert property (mchk_take ==
    (state_out[b_mchk_async_gate] && mchk_async_req)) else $error("mchk gate");
  chk_dbg_gate: assert property (dbg_take ==
    (state_out[b_dbg_irq_gate] && dbg_req)) else $error("debug gate");
  chk_priv_refuse: assert property (priv_fault ==
    (insn_valid && insn_privileged && state_out[b_user_mode_flag])) else $error("priv fault");
  chk_lock_refuse: assert property (insn_valid && insn_cache_lock
    && state_out[b_user_mode_flag] |-> lock_fault == !state_out[b_user_lock_permit])
    else $error("lock fault");
  chk_lock_flags: assert property ({set_data_lock_flag, set_ifetch_lock_flag} ==
    ({2{insn_valid && insn_cache_lock && state_out[b_user_mode_flag]
    && !state_out[b_user_lock_permit]}} & {insn_lock_is_data, !insn_lock_is_data}))
    else $error("lock flag");
  chk_vector_refuse: assert property (vector_unavail ==
    (insn_valid && insn_vector && !state_out[b_vector_unit_avail])) else $error("vector");
  chk_float_unavail: assert property (float_unavail ==
    (insn_valid && insn_float && !state_out[b_float_avail])) else $error("float unavail");
  chk_float_unimpl: assert property (unimpl_op ==
    (insn_valid && insn_float && state_out[b_float_avail])) else $error("unimpl op");
  chk_mchk_entry: assert property (mchk_take || mchk_sync_req |=> state_out == 32'h0)
    else $error("state not cleared on mchk");
  chk_idle_permit: assert property (idle_light |->
    $past(state_out[b_idle_permit]) && $past(idle_request)) else $error("idle no permit");
  cov_mchk: cover property (mchk_take);
  cov_lock: cover property (lock_fault);
  cov_idle: cover property (idle_light);
endmodule : proc_state_checker
`default_nettype wire

// *** verification/processor_state_register_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module processor_state_register_tb;
  import proc_state_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [addr_w-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, resume_addr, state_out, core_rnd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic mchk_async_req, mchk_sync_req, dbg_req, crit_in_req, watchdog_req, ext_in_req;
  logic decr_req, fit_req, ret_mchk, ret_dbg, idle_request, insn_valid, insn_privileged;
  logic insn_cache_lock, insn_lock_is_data, insn_vector, insn_float, crit_take, ext_take;
  logic mchk_take, dbg_take, priv_fault, lock_fault, set_data_lock_flag, set_ifetch_lock_flag;
  logic vector_unavail, float_unavail, unimpl_op, idle_light, idle_medium, idle_deep;
  logic [31:0] seed = 32'h8983D6A3;
  logic [31:0] model [7];
  int failures = 0;
  int samples_checked = 0;
  processor_state_register i_processor_state_register (.*);
  core_side_model i_core_side_model (.*, .rnd(core_rnd));
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  always @(posedge aclk)
    core_rnd <= rnd();
  function automatic logic [31:0] merge(input logic [31:0] o, d, input logic [3:0] s,
    input logic [31:0] m);
    logic [31:0] e;
    e = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return ((o & ~e) | (d & e)) & m;
  endfunction : merge
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic give_up();
    failures++;
    tally_and_finish();
  endtask : give_up
  task automatic check(input string name, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wrchk(input logic [addr_w-1:0] a, input logic [31:0] d,
    input logic [3:0] s, input logic [1:0] rx);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && n < 99);
    if (!s_axi_bvalid)
      give_up();
    check("bresp", s_axi_bresp, rx);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wrchk
  task automatic rdchk(input string name, input logic [addr_w-1:0] a,
    input logic [31:0] x, input logic [1:0] rx);
    int n;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && n < 99);
    if (!s_axi_rvalid)
      give_up();
    check(name, s_axi_rdata, x);
    check("rresp", s_axi_rresp, rx);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rdchk
  initial
  begin
    logic [31:0] w, ra;
    logic [3:0] s;
    logic [addr_w-1:0] a;
    int k;
    int i;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, resume_addr} = '0;
    {mchk_async_req, mchk_sync_req, dbg_req, ret_mchk, ret_dbg} = '0;
    model = '{default: 32'h0};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (k = 0; k < 7; k++)
      rdchk("reset", addr_w'(4 * k), 32'h0, resp_okay);
    wrchk(off_state, 32'hFFFFFFFF, 4'hF, resp_okay);
    rdchk("mask", off_state, state_mask, resp_okay);
    model[0] = state_mask;
    for (k = 0; k < 30; k++)
    begin
      a = rnd() & 1 ? off_config : off_state;
      w = rnd();
      s = w[7:4];
      i = a >> 2;
      model[i] = merge(model[i], w, s, i == 0 ? state_mask : config_mask);
      wrchk(a, w, s, resp_okay);
      check("state_out", state_out, model[0]);
      rdchk("readback", a, model[i], resp_okay);
    end
    wrchk(6'h1C, 32'hFFFFFFFF, 4'hF, resp_slverr);
    rdchk("unmapped", 6'h1C, 32'h0, resp_slverr);
    check("state_out", state_out, model[0]);
    wrchk(off_config, 32'h8, 4'hF, resp_okay);
    for (k = 0; k < 3; k++)
    begin
      w = (rnd() & state_mask) | (32'h1 << b_mchk_async_gate) | (32'h1 << b_dbg_irq_gate);
      ra = rnd();
      wrchk(off_state, w, 4'hF, resp_okay);
      resume_addr <= ra;
      mchk_sync_req <= (k == 0);
      mchk_async_req <= (k == 1);
      dbg_req <= (k == 2);
      @(posedge aclk);
      {mchk_sync_req, mchk_async_req, dbg_req} <= 3'b000;
      @(posedge aclk);
      check("entry", state_out, k < 2 ? 32'h0 : w & ~(32'h1 << b_dbg_irq_gate));
      a = k < 2 ? off_mchk_addr : off_dbg_addr;
      rdchk("ret_addr", a, ra, resp_okay);
      rdchk("saved", a + 6'h04, w, resp_okay);
      rdchk("status", off_status, k < 2 ? 32'h1 : 32'h2, resp_okay);
      ret_mchk <= (k < 2);
      ret_dbg <= (k == 2);
      @(posedge aclk);
      {ret_mchk, ret_dbg} <= 2'b00;
      @(posedge aclk);
      check("restore", state_out, w);
    end
    wrchk(off_config, 32'h5, 4'hF, resp_okay);
    for (i = 0; i < 2; i++)
    begin
      wrchk(off_state, i == 0 ? 32'h1 << b_idle_permit : 32'h0, 4'hF, resp_okay);
      for (k = 0; k < 20; k++)
      begin
        @(posedge aclk);
        if (k > 0)
          check("idle", {29'h0, idle_deep, idle_medium, idle_light}, {29'h0, ra[0], 1'b0, ra[0]});
        ra[0] = idle_request & (i == 0);
      end
    end
    tally_and_finish();
  end
endmodule : processor_state_register_tb
bind processor_state_register proc_state_checker i_proc_state_checker (.*);
`default_nettype wire
